/* File: rx_recovery_pkg.sv */
// receive recovery package: frame sizes, sample points, states
// assumes a baud generator supplies one oversample tick per sample period
package rx_recovery_pkg;
	localparam logic [3:0] SAMPLES_NORMAL = 4'hf;  // last state index, 16 states
	localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;  // last state index, 8 states
	localparam logic [3:0] VOTE_FIRST_N   = 4'h8;
	localparam logic [3:0] VOTE_FIRST_D   = 4'h4;
	localparam logic [3:0] DATA_MIN       = 4'h5;
	localparam logic [3:0] DATA_MAX       = 4'h9;  // 9 data bits max, plus parity = 10
	localparam logic [3:0] BITS_MAX       = 4'ha;
	localparam logic [9:0] SHIFT_RESET    = 10'h000;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_BITS  = 4'b0100,
		ST_STOP  = 4'b1000
	} rx_state_e;

	// three-sample majority
	function automatic logic vote3(input logic [2:0] s);
		vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction
endpackage

/* File: rx_vote_sampler.sv */
// three-sample majority collector for one bit period
// assumes sample_en pulses once per oversample tick with state number given
`timescale 1ns/1ps
module rx_vote_sampler (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	// sampling
	input  wire logic       sample_en_i,
	input  wire logic       line_i,
	input  wire logic [3:0] state_i,
	input  wire logic [3:0] first_i,
	// result
	output logic            voted_o,
	output logic            vote_done_o
);
	import rx_recovery_pkg::*;

	typedef struct packed {
		logic [2:0] smp;
		logic       voted;
		logic       done;
	} vote_s;

	vote_s st_r;
	vote_s st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (sample_en_i) begin
			if (state_i == first_i) st_nxt.smp[0] = line_i;
			if (state_i == first_i + 4'h1) st_nxt.smp[1] = line_i;
			if (state_i == first_i + 4'h2) begin
				st_nxt.voted = vote3({line_i, st_r.smp[1], st_r.smp[0]});
				st_nxt.done  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) st_r <= '0;
		else st_r <= st_nxt;
	end

	assign voted_o     = st_r.voted;
	assign vote_done_o = st_r.done;
endmodule

/* File: uart_async_rx_recovery.sv */
// asynchronous receive recovery: start qualification and bit voting
// assumes rx line already synchronised; tick from the baud generator
`timescale 1ns/1ps
module uart_async_rx_recovery (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	// configuration
	input  wire logic       rx_enable_i,
	input  wire logic       double_speed_select_i,
	input  wire logic [3:0] data_bits_i,
	input  wire logic       parity_en_i,
	// line
	input  wire logic       sample_tick_i,
	input  wire logic       rx_line_i,
	// frame out
	output logic [9:0]      frame_data_o,
	output logic            stop_bit_fault_flag_o,
	output logic            frame_valid_o,
	output logic            busy_o
);
	import rx_recovery_pkg::*;

	typedef struct packed {
		rx_state_e  state;
		logic [3:0] phase;
		logic [3:0] bit_idx;
		logic [3:0] nbits;
		logic       line_d;
		logic [9:0] shift;
		logic [9:0] data;
		logic       fault;
		logic       valid;
		logic       busy;
	} rx_s;

	rx_s st_r;
	rx_s st_nxt;

	logic       voted;
	logic       vote_done;
	logic [3:0] last_phase;
	logic [3:0] first_vote;
	logic [3:0] dbits;

	// clamp odd character sizes into the legal span
	assign dbits      = (data_bits_i < DATA_MIN) ? DATA_MIN :
	                    (data_bits_i > DATA_MAX) ? DATA_MAX : data_bits_i;
	assign last_phase = double_speed_select_i ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
	assign first_vote = double_speed_select_i ? VOTE_FIRST_D : VOTE_FIRST_N;

	rx_vote_sampler u_vote (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.sample_en_i (sample_tick_i && st_r.state != ST_IDLE),
		.line_i      (rx_line_i),
		.state_i     (st_r.phase),
		.first_i     (first_vote),
		.voted_o     (voted),
		.vote_done_o (vote_done)
	);

	always_comb begin
		st_nxt       = st_r;
		st_nxt.valid = 1'b0;
		if (sample_tick_i) begin
			st_nxt.line_d = rx_line_i;
			if (st_r.state != ST_IDLE) st_nxt.phase = (st_r.phase == last_phase) ? 4'h0 :
			                                         st_r.phase + 4'h1;
		end
		case (st_r.state)
			ST_IDLE: begin
				// first low sample is numbered one
				if (sample_tick_i && st_r.line_d && !rx_line_i) begin
					st_nxt.state = ST_START;
					st_nxt.phase = 4'h2;
				end
			end
			ST_START: begin
				if (vote_done) begin
					if (voted) begin
						st_nxt.state = ST_IDLE;
					end else begin
						st_nxt.state   = ST_BITS;
						st_nxt.bit_idx = 4'h0;
						st_nxt.nbits   = dbits + {3'h0, parity_en_i};
						st_nxt.shift   = SHIFT_RESET;
					end
				end
			end
			ST_BITS: begin
				if (vote_done) begin
					st_nxt.shift   = st_r.shift | ({9'h0, voted} << st_r.bit_idx);
					st_nxt.bit_idx = st_r.bit_idx + 4'h1;
					if (st_r.bit_idx + 4'h1 == st_r.nbits) st_nxt.state = ST_STOP;
				end
			end
			ST_STOP: begin
				if (vote_done) begin
					// later stop bits are never sampled
					st_nxt.data  = st_r.shift;
					st_nxt.fault = !voted;
					st_nxt.valid = 1'b1;
					// normal rearms with the last vote sample as line history, so a
					// low stop bit cannot fake an edge; double waits for a fresh high
					st_nxt.state = ST_IDLE;
					if (double_speed_select_i) st_nxt.line_d = 1'b0;
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase
		if (!rx_enable_i) begin
			st_nxt.state = ST_IDLE;
			st_nxt.phase = 4'h0;
		end
		st_nxt.busy = (st_nxt.state != ST_IDLE);
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r        <= '0;
			st_r.state  <= ST_IDLE;
			st_r.line_d <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign frame_data_o          = st_r.data;
	assign stop_bit_fault_flag_o = st_r.fault;
	assign frame_valid_o         = st_r.valid;
	assign busy_o                = st_r.busy;
endmodule

/* File: uart_rx_assertions.sv */
// checker on the recovery top's ports; bound from the bench
`timescale 1ns/1ps
module uart_rx_chk (
	input wire logic       ref_clk_i,
	input wire logic       reset_n_i,
	input wire logic       rx_enable_i,
	input wire logic       sample_tick_i,
	input wire logic [9:0] frame_data_o,
	input wire logic       stop_bit_fault_flag_o,
	input wire logic       frame_valid_o,
	input wire logic       busy_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	valid_gap_a: assert property (frame_valid_o |=> !frame_valid_o [*8])
		else $error("valid gap");
	valid_busy_a: assert property (frame_valid_o |-> $past(busy_o))
		else $error("valid idle");
	valid_tick_a: assert property (frame_valid_o |-> $past(sample_tick_i, 2))
		else $error("valid lag");
	busy_tick_a: assert property ($rose(busy_o) |-> $past(sample_tick_i))
		else $error("busy start");
	enable_drop_a: assert property (!rx_enable_i |=> !busy_o)
		else $error("busy off");
	valid_enable_a: assert property (frame_valid_o |-> $past(rx_enable_i))
		else $error("valid off");
	data_hold_a: assert property (!frame_valid_o |-> $stable(frame_data_o))
		else $error("data hold");
	fault_hold_a: assert property (!frame_valid_o |-> $stable(stop_bit_fault_flag_o))
		else $error("fault hold");
endmodule

/* File: uart_tx_model.sv */
// far transmitter: one bit per spb ticks, exact receiver rate
`timescale 1ns/1ps
module uart_tx_model (
	input wire logic ref_clk_i,
	input wire logic sample_tick_i,
	output logic     line_o
);
	initial line_o = 1'b1;
	// no rate error, so well inside tolerance
	task automatic send(input logic [11:0] f, input int n, input int spb);
		for (int i = 0; i < n; i++) begin
			@(negedge ref_clk_i);
			line_o = f[i];
			repeat (spb) @(posedge ref_clk_i iff sample_tick_i);
		end
		@(negedge ref_clk_i);
		line_o = 1'b1;
	endtask
endmodule

/* File: uart_async_rx_recovery_test.sv */
// bench: speeds, sizes, fault, noise, abort; model and checker compile first
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t %h %h", $time, a, b); end end
module uart_async_rx_recovery_test;
	logic       clk = 0, rst_n = 0, en = 1, ds = 0, pe = 0, tk = 0, ln, fe, vl, bs, gf;
	logic [3:0] db = 4'h8;
	logic [9:0] dq, gd;
	int         n_mismatch = 0, num_checks = 0, nf = 0;
	initial forever #10 clk = ~clk;
	always @(negedge clk) tk <= ~tk;
	always @(posedge clk) if (vl) begin
		nf++;
		gd = dq;
		gf = fe;
	end
	uart_async_rx_recovery i_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .rx_enable_i(en),
		.double_speed_select_i(ds), .data_bits_i(db), .parity_en_i(pe), .sample_tick_i(tk),
		.rx_line_i(ln), .frame_data_o(dq), .stop_bit_fault_flag_o(fe), .frame_valid_o(vl),
		.busy_o(bs));
	uart_tx_model i_tx (.ref_clk_i(clk), .sample_tick_i(tk), .line_o(ln));
	task automatic run(input logic s, input int b, input logic p, input logic [9:0] d,
		input logic t);
		logic [11:0] f;
		int          n;
		f = {1'b1, d, 1'b0};
		f[b + p + 1] = t;
		n = nf;
		@(negedge clk);
		ds = s;
		db = b[3:0];
		pe = p;
		i_tx.send(f, b + p + 2, s ? 8 : 16);
		`CHK(nf, n + 1)
		`CHK(gd, d)
		`CHK(gf, !t)
	endtask
	task automatic t_b2b;
		run(0, 8, 0, 10'h0a5, 1);
		run(0, 8, 0, 10'h05a, 1);
	endtask
	task automatic t_dbl;
		run(1, 5, 0, 10'h015, 1);
		run(1, 9, 1, 10'h3a5, 1);
	endtask
	task automatic t_fault;
		run(0, 7, 1, 10'h0c3, 0);
	endtask
	task automatic t_noise;
		int n;
		n = nf;
		i_tx.send(12'h002, 2, 3);
		repeat (40) @(negedge clk);
		`CHK(bs, 1'b0)
		`CHK(nf, n)
	endtask
	task automatic t_abort;
		int n;
		n = nf;
		i_tx.send(12'h000, 3, 16);
		`CHK(bs, 1'b1)
		en = 0;
		@(negedge clk);
		`CHK(bs, 1'b0)
		en = 1;
		repeat (400) @(negedge clk);
		`CHK(nf, n)
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		t_b2b;
		t_dbl;
		t_fault;
		t_noise;
		t_abort;
		close_out;
	end
	// all tests need under 5000 clocks
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out;
	end
endmodule
bind uart_async_rx_recovery uart_rx_chk i_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
	.rx_enable_i(rx_enable_i), .sample_tick_i(sample_tick_i), .frame_data_o(frame_data_o),
	.stop_bit_fault_flag_o(stop_bit_fault_flag_o), .frame_valid_o(frame_valid_o),
	.busy_o(busy_o));
